// *** verilog/psp_consts.vh ***
// Purpose: Constants for the byte-wide parallel slave port block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Offsets and bit positions used by the port logic
`ifndef PSP_CONSTS_VH
`define PSP_CONSTS_VH

`define PSP_OFF_CTRL      12'h000
`define PSP_OFF_PRIO      12'h004
`define PSP_OFF_DIN       12'h008
`define PSP_OFF_DOUT      12'h00C
`define PSP_OFF_IRQ_STAT  12'h010
`define PSP_OFF_IRQ_MASK  12'h014
`define PSP_OFF_GPIO      12'h018
`define PSP_OFF_SYS       12'h01C

`define PSP_BIT_IBF       7
`define PSP_BIT_OBF       6
`define PSP_BIT_INPUT_OVERFLOW_FLAG      5
`define PSP_BIT_MODE      4
`define PSP_BIT_PRIO      7

`define PSP_PRIO_RST      8'hFF
`define PSP_CTRL_RST      8'h00
`define PSP_CTRL_WMASK    8'h30

`define PSP_EV_RX         0
`define PSP_EV_TX         1
`define PSP_EV_OVF        2
`define PSP_EV_W          3

`endif

// *** verilog/psp_sync_strobe.v ***
// Purpose: Detect the closing edge of a host strobe qualified by select
// Assumes: Inputs synchronous to i_clk, active-low select and strobe
// Notes:   Pulse fires once per access, when the strobe is released
`timescale 1ns/10ps
module psp_sync_strobe (
    input  wire i_clk,
    input  wire i_reset,
    input  wire i_ce,
    input  wire i_cs_n,
    input  wire i_strobe_n,
    output wire o_active,
    output reg  o_done
);
    reg act_r;

    assign o_active = ~i_cs_n & ~i_strobe_n;

    // Acting on release lets the data settle for the whole strobe
    always @(posedge i_clk) begin
        if (i_reset) begin
            act_r  <= 1'b0;
            o_done <= 1'b0;
        end else if (i_ce) begin
            act_r  <= o_active;
            o_done <= act_r & ~o_active;
        end
    end
endmodule

// *** verilog/psp_irq_prio.v ***
// Purpose: Route the port interrupt to the high or low priority line
// Assumes: Priority scheme enable comes from the system control bit
// Notes:   With the scheme off every request goes to the high line
`timescale 1ns/10ps
module psp_irq_prio (
    input  wire i_req,
    input  wire i_prio_bit,
    input  wire i_scheme_en,
    output wire o_high,
    output wire o_low
);
    wire use_high;

    // Priority bit only counts while the scheme is enabled
    assign use_high = ~i_scheme_en | i_prio_bit;
    assign o_high   = i_req & use_high;
    assign o_low    = i_req & ~use_high;
endmodule

// *** verilog/psp_top.v ***
// Purpose: Byte-wide parallel slave port with APB register access
// Assumes: Host pins synchronous to i_clk; APB slave, zero wait states
// Notes:   Host strobes are active low; data bus is a split tristate
//          Set beats clear on every flag that both sides touch
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "psp_consts.vh"
module psp_top (
    input  wire        i_clk,
    input  wire        i_reset,
    input  wire        i_ce,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    input  wire        i_cs_n,
    input  wire        i_wr_n,
    input  wire        i_rd_n,
    input  wire [7:0]  i_host_data_bus,
    output reg  [7:0]  o_host_data_bus,
    output reg  [7:0]  o_host_data_oe,
    output reg         o_irq,
    output reg         o_irq_high,
    output reg         o_irq_low
);
    reg  [7:0] ctrl_r;
    reg  [7:0] prio_r;
    reg  [7:0] din_r;
    reg  [7:0] dout_r;
    reg  [7:0] gpio_out_r;
    reg  [7:0] gpio_oe_r;
    reg        scheme_en_r;
    reg  [3:0] stat_r;
    reg  [3:0] mask_r;
    reg  [3:0] stat_nxt;
    reg  [7:0] ctrl_nxt;
    reg  [31:0] rdata_nxt;
    reg        slverr_nxt;
    reg  [7:0] prio_nxt;
    reg  [3:0] mask_nxt;
    reg  [7:0] gpio_out_nxt;
    reg  [7:0] gpio_oe_nxt;
    reg        scheme_en_nxt;
    reg  [7:0] din_nxt;
    reg  [7:0] dout_nxt;
    reg  [31:0] prdata_nxt;
    reg        pready_nxt;
    reg        pslverr_nxt;
    reg  [7:0] bus_nxt;
    reg  [7:0] bus_oe_nxt;

    wire       port_mode;
    wire       wr_active;
    wire       wr_done;
    wire       rd_active;
    wire       rd_done;
    wire       apb_setup;
    wire       apb_wr;
    wire       apb_rd;
    wire       irq_req;
    wire       irq_hi;
    wire       irq_lo;
    wire [3:0] events;

    function is_reg;
        input [11:0] addr;
        input [11:0] off;
        begin
            is_reg = (addr == off);
        end
    endfunction

    // Byte registers read back in the low lane of the word
    function [31:0] lane0;
        input [7:0] val;
        begin
            lane0 = {24'h00_0000, val};
        end
    endfunction

    function wr_hit;
        input        wr;
        input [11:0] addr;
        input [11:0] off;
        begin
            wr_hit = wr & (addr == off);
        end
    endfunction

    assign port_mode = ctrl_r[`PSP_BIT_MODE];

    psp_sync_strobe u_wr (
        .i_clk      (i_clk),
        .i_reset    (i_reset),
        .i_ce       (i_ce),
        .i_cs_n     (i_cs_n),
        .i_strobe_n (i_wr_n),
        .o_active   (wr_active),
        .o_done     (wr_done)
    );

    psp_sync_strobe u_rd (
        .i_clk      (i_clk),
        .i_reset    (i_reset),
        .i_ce       (i_ce),
        .i_cs_n     (i_cs_n),
        .i_strobe_n (i_rd_n),
        .o_active   (rd_active),
        .o_done     (rd_done)
    );

    // Access phase is answered in the cycle it starts
    assign apb_setup = i_psel & ~i_penable;
    assign apb_wr    = i_psel & i_penable & i_pwrite & o_pready;
    assign apb_rd    = i_psel & i_penable & ~i_pwrite & o_pready;

    wire host_wr = port_mode & wr_done;
    wire host_rd = port_mode & rd_done;
    // Decoded accesses, each one cycle wide at the access edge
    wire cpu_rd_din  = apb_rd & is_reg(i_paddr, `PSP_OFF_DIN);
    wire cpu_wr_dout = apb_wr & is_reg(i_paddr, `PSP_OFF_DOUT);
    wire cpu_rd_stat = apb_rd & is_reg(i_paddr, `PSP_OFF_IRQ_STAT);
    wire cpu_wr_ctrl = wr_hit(apb_wr, i_paddr, `PSP_OFF_CTRL);

    assign events[`PSP_EV_RX]  = host_wr;
    assign events[`PSP_EV_TX]  = host_rd;
    assign events[`PSP_EV_OVF] = host_wr & ctrl_r[`PSP_BIT_IBF];
    assign events[`PSP_EV_W]   = 1'b0;

    // Control register: status bits move by hardware, set beats clear
    always @* begin
        ctrl_nxt = ctrl_r;
        if (cpu_wr_ctrl) begin
            ctrl_nxt = (ctrl_r & ~`PSP_CTRL_WMASK)
                     | (i_pwdata[7:0] & `PSP_CTRL_WMASK);
            // Overflow can only be cleared by software, never set
            ctrl_nxt[`PSP_BIT_INPUT_OVERFLOW_FLAG] = ctrl_r[`PSP_BIT_INPUT_OVERFLOW_FLAG]
                                    & i_pwdata[`PSP_BIT_INPUT_OVERFLOW_FLAG];
        end
        if (cpu_rd_din)
            ctrl_nxt[`PSP_BIT_IBF] = 1'b0;
        if (host_wr)
            ctrl_nxt[`PSP_BIT_IBF] = 1'b1;
        if (events[`PSP_EV_OVF])
            ctrl_nxt[`PSP_BIT_INPUT_OVERFLOW_FLAG] = 1'b1;
        if (host_rd)
            ctrl_nxt[`PSP_BIT_OBF] = 1'b0;
        if (cpu_wr_dout)
            ctrl_nxt[`PSP_BIT_OBF] = 1'b1;
        ctrl_nxt[3:0] = 4'h0;
    end

    // Read clears status, but a new event in that cycle survives
    always @* begin
        stat_nxt = stat_r;
        if (cpu_rd_stat)
            stat_nxt = 4'h0;
        stat_nxt = stat_nxt | events;
    end

    always @* begin
        rdata_nxt  = 32'h0000_0000;
        slverr_nxt = 1'b0;
        case (i_paddr)
            `PSP_OFF_CTRL:     rdata_nxt = lane0({ctrl_r[7:4], 4'h0});
            `PSP_OFF_PRIO:     rdata_nxt = lane0(prio_r);
            `PSP_OFF_DIN:      rdata_nxt = lane0(din_r);
            `PSP_OFF_DOUT:     rdata_nxt = lane0(dout_r);
            `PSP_OFF_IRQ_STAT: rdata_nxt = lane0({4'h0, stat_r});
            `PSP_OFF_IRQ_MASK: rdata_nxt = lane0({4'h0, mask_r});
            `PSP_OFF_GPIO:     rdata_nxt = {16'h0000, gpio_oe_r, gpio_out_r};
            `PSP_OFF_SYS:      rdata_nxt = lane0({7'h00, scheme_en_r});
            default:           slverr_nxt = 1'b1;
        endcase
    end

    // Answer is launched at the setup edge and stands one cycle,
    // so the access phase never sees a wait state
    always @* begin
        pready_nxt  = apb_setup;
        prdata_nxt  = o_prdata;
        pslverr_nxt = 1'b0;
        if (apb_setup) begin
            prdata_nxt  = i_pwrite ? 32'h0000_0000 : rdata_nxt;
            pslverr_nxt = slverr_nxt;
        end
    end

    // Software-written registers; unmapped writes fall through
    always @* begin
        prio_nxt      = prio_r;
        mask_nxt      = mask_r;
        gpio_out_nxt  = gpio_out_r;
        gpio_oe_nxt   = gpio_oe_r;
        scheme_en_nxt = scheme_en_r;
        dout_nxt      = dout_r;
        din_nxt       = din_r;
        // Mask and priority take effect at the access edge
        if (wr_hit(apb_wr, i_paddr, `PSP_OFF_PRIO))
            prio_nxt = i_pwdata[7:0];
        if (wr_hit(apb_wr, i_paddr, `PSP_OFF_IRQ_MASK))
            mask_nxt = i_pwdata[3:0];
        if (wr_hit(apb_wr, i_paddr, `PSP_OFF_GPIO)) begin
            gpio_out_nxt = i_pwdata[7:0];
            gpio_oe_nxt  = i_pwdata[15:8];
        end
        if (wr_hit(apb_wr, i_paddr, `PSP_OFF_SYS))
            scheme_en_nxt = i_pwdata[0];
        if (cpu_wr_dout)
            dout_nxt = i_pwdata[7:0];
        // Overflow keeps the newest byte, the older one is lost
        if (host_wr)
            din_nxt = i_host_data_bus;
    end

    // A frozen enable holds every register, strobe history included
    always @(posedge i_clk) begin
        if (i_reset) begin
            ctrl_r      <= `PSP_CTRL_RST;
            prio_r      <= `PSP_PRIO_RST;
            din_r       <= 8'h00;
            dout_r      <= 8'h00;
            gpio_out_r  <= 8'h00;
            gpio_oe_r   <= 8'h00;
            scheme_en_r <= 1'b0;
            stat_r      <= 4'h0;
            mask_r      <= 4'h0;
            o_prdata    <= 32'h0000_0000;
            o_pready    <= 1'b0;
            o_pslverr   <= 1'b0;
        end else if (i_ce) begin
            ctrl_r      <= ctrl_nxt;
            stat_r      <= stat_nxt;
            prio_r      <= prio_nxt;
            mask_r      <= mask_nxt;
            din_r       <= din_nxt;
            dout_r      <= dout_nxt;
            gpio_out_r  <= gpio_out_nxt;
            gpio_oe_r   <= gpio_oe_nxt;
            scheme_en_r <= scheme_en_nxt;
            o_prdata    <= prdata_nxt;
            o_pready    <= pready_nxt;
            o_pslverr   <= pslverr_nxt;
        end
    end

    // GPIO mode hands the pins back to the software registers
    always @* begin
        if (port_mode) begin
            bus_nxt    = dout_r;
            bus_oe_nxt = {8{rd_active}};
        end else begin
            bus_nxt    = gpio_out_r;
            bus_oe_nxt = gpio_oe_r;
        end
    end

    // Bus drive follows the read strobe one cycle later
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_host_data_bus <= 8'h00;
            o_host_data_oe  <= 8'h00;
        end else if (i_ce) begin
            o_host_data_bus <= bus_nxt;
            o_host_data_oe  <= bus_oe_nxt;
        end
    end

    assign irq_req = |(stat_r & mask_r);

    psp_irq_prio u_prio (
        .i_req       (irq_req),
        .i_prio_bit  (prio_r[`PSP_BIT_PRIO]),
        .i_scheme_en (scheme_en_r),
        .o_high      (irq_hi),
        .o_low       (irq_lo)
    );

    always @(posedge i_clk) begin
        if (i_reset) begin
            o_irq      <= 1'b0;
            o_irq_high <= 1'b0;
            o_irq_low  <= 1'b0;
        end else if (i_ce) begin
            o_irq      <= irq_req;
            o_irq_high <= irq_hi;
            o_irq_low  <= irq_lo;
        end
    end
endmodule

// *** bench/psp_top_assertions.sv ***
// Purpose: Port checks for psp_top
// Assumes: Clock enable held high
// Notes:   Bound to every psp_top instance
`timescale 1ns/10ps
module psp_top_assertions (
    input wire        i_clk,
    input wire        i_reset,
    input wire        i_ce,
    input wire        i_psel,
    input wire        i_penable,
    input wire        i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] o_prdata,
    input wire        o_pready,
    input wire        o_pslverr,
    input wire        o_irq,
    input wire        o_irq_high,
    input wire        o_irq_low
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset || !i_ce);
    a_ready_setup: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready too long");
    a_ready_access: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside access");
    a_err_ready: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    a_unmapped_err: assert property (o_pready && i_paddr > 12'h01C
        |-> o_pslverr && o_prdata == 32'h0000_0000)
        else $error("unmapped not refused");
    a_ctrl_low: assert property (o_pready && !i_pwrite
        && i_paddr == 12'h000 |-> o_prdata[3:0] == 4'h0)
        else $error("control low bits set");
    a_irq_excl: assert property (!(o_irq_high && o_irq_low))
        else $error("both vectors high");
    a_reset_quiet: assert property ($fell(i_reset) |-> !o_irq)
        else $error("irq after reset");
    c_err: cover property (o_pslverr);
    c_low: cover property (o_irq_low);
    c_high: cover property (o_irq_high);
endmodule
bind psp_top psp_top_assertions u_chk (.i_clk(i_clk), .i_reset(i_reset),
    .i_ce(i_ce),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_irq(o_irq), .o_irq_high(o_irq_high),
    .o_irq_low(o_irq_low));

// *** bench/psp_host_model.sv ***
// Purpose: Host processor on the parallel port
// Assumes: Strobes change just after a rising edge
// Notes:   Released bus shows the inverse of the last byte
`timescale 1ns/10ps
module psp_host_model (
    input  wire       i_clk,
    input  wire [7:0] i_dev_data,
    input  wire [7:0] i_dev_oe,
    output logic      o_cs_n,
    output logic      o_wr_n,
    output logic      o_rd_n,
    output wire [7:0] o_bus
);
    logic       drv = 1'b0;
    logic [7:0] val = 8'h00;
    initial begin
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
    end
    assign o_bus = (i_dev_oe & i_dev_data) | (~i_dev_oe & (drv ? val : ~val));
    task hwrite(input logic [7:0] d);
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        o_wr_n <= 1'b0;
        drv <= 1'b1;
        val <= d;
        @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_wr_n <= 1'b1;
        // Data held past release so a late capture still sees it
        repeat (2) @(posedge i_clk);
        drv <= 1'b0;
    endtask
    task hread(output logic [7:0] d);
        int n;
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        o_rd_n <= 1'b0;
        n = 0;
        // Drive enable is sampled at the rising edge, as the bus sees it
        do begin
            @(posedge i_clk);
            n++;
        end while (i_dev_oe !== 8'hFF && n < 8);
        d = (i_dev_oe === 8'hFF) ? o_bus : 8'hxx;
        o_cs_n <= 1'b1;
        o_rd_n <= 1'b1;
        @(posedge i_clk);
    endtask
endmodule

// *** bench/psp_top_tb.sv ***
// Purpose: Self-checking bench for psp_top
// Assumes: Clock enable held high except while t_ce drops it
// Notes:   Interrupt and pin outputs sampled at the falling edge; APB data at the rising edge
`timescale 1ns/10ps
`include "psp_consts.vh"
module psp_top_tb;
    logic        i_clk = 0, i_reset = 1, psel = 0, pen = 0, pwr = 0, ce = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic [7:0]  hbus, hout, hoe, b;
    logic        pready, pslverr, rerr, cs_n, wr_n, rd_n, irq, irqh, irql;
    int          err_count = 0, cmp_count = 0;
    always #2 i_clk = ~i_clk;
    psp_host_model u_host (.i_clk(i_clk), .i_dev_data(hout),
        .i_dev_oe(hoe), .o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n),
        .o_bus(hbus));
    psp_top u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n),
        .i_host_data_bus(hbus), .o_host_data_bus(hout),
        .o_host_data_oe(hoe), .o_irq(irq), .o_irq_high(irqh),
        .o_irq_low(irql));
    task complete_run;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        int n;
        @(posedge i_clk);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge i_clk);
        pen <= 1;
        n = 0;
        // Ready and read data are taken at the same rising edge
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            complete_run;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    task rdc(input logic [11:0] a, input logic [7:0] e);
        apb(0, a, 16'h0000);
        chk(rdat, {24'h00_0000, e});
    endtask
    task ichk(input logic [2:0] e);
        repeat (2) @(negedge i_clk);
        chk({29'h0, irq, irqh, irql}, {29'h0, e});
    endtask
    task t_reset;
        rdc(`PSP_OFF_CTRL, 8'h00);
        rdc(`PSP_OFF_PRIO, 8'hFF);
        rdc(12'h020, 8'h00);
        chk({31'h0, rerr}, 32'h0000_0001);
    endtask
    task t_gpio;
        apb(1, `PSP_OFF_GPIO, 16'hFF5A);
        repeat (2) @(negedge i_clk);
        chk({16'h0000, hoe, hout}, 32'h0000_FF5A);
        u_host.hwrite(8'h11);
        rdc(`PSP_OFF_CTRL, 8'h00);
        apb(1, `PSP_OFF_GPIO, 16'h0000);
    endtask
    task t_write;
        apb(1, `PSP_OFF_CTRL, 16'h0010);
        apb(1, `PSP_OFF_IRQ_MASK, 16'h0007);
        u_host.hwrite(8'hA5);
        rdc(`PSP_OFF_CTRL, 8'h90);
        ichk(3'h6);
        rdc(`PSP_OFF_IRQ_STAT, 8'h01);
        ichk(3'h0);
        rdc(`PSP_OFF_DIN, 8'hA5);
        rdc(`PSP_OFF_CTRL, 8'h10);
        u_host.hwrite(8'h01);
        u_host.hwrite(8'h02);
        rdc(`PSP_OFF_CTRL, 8'hB0);
        rdc(`PSP_OFF_IRQ_STAT, 8'h05);
        rdc(`PSP_OFF_DIN, 8'h02);
        apb(1, `PSP_OFF_CTRL, 16'h00FF);
        rdc(`PSP_OFF_CTRL, 8'h30);
        apb(1, `PSP_OFF_CTRL, 16'h0010);
        rdc(`PSP_OFF_CTRL, 8'h10);
    endtask
    task t_prio;
        u_host.hwrite(8'h33);
        apb(1, `PSP_OFF_SYS, 16'h0001);
        apb(1, `PSP_OFF_PRIO, 16'h007F);
        ichk(3'h5);
        apb(1, `PSP_OFF_PRIO, 16'h00FF);
        ichk(3'h6);
        apb(1, `PSP_OFF_PRIO, 16'h007F);
        apb(1, `PSP_OFF_SYS, 16'h0000);
        ichk(3'h6);
        rdc(`PSP_OFF_DIN, 8'h33);
        rdc(`PSP_OFF_IRQ_STAT, 8'h01);
    endtask
    task t_read;
        apb(1, `PSP_OFF_DOUT, 16'h003C);
        rdc(`PSP_OFF_CTRL, 8'h50);
        u_host.hread(b);
        chk({24'h00_0000, b}, 32'h0000_003C);
        rdc(`PSP_OFF_CTRL, 8'h10);
        rdc(`PSP_OFF_IRQ_STAT, 8'h02);
    endtask
    // A host write while the enable is low must leave no trace
    task t_ce;
        @(posedge i_clk);
        ce <= 0;
        u_host.hwrite(8'h77);
        @(posedge i_clk);
        ce <= 1;
        rdc(`PSP_OFF_CTRL, 8'h10);
        rdc(`PSP_OFF_IRQ_STAT, 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_reset <= 0;
        t_reset;
        t_gpio;
        t_write;
        t_prio;
        t_read;
        t_ce;
        complete_run;
    end
endmodule
